// [rtl/bbf_ctrl.v]
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "bbf_map.vh"

// Summary of operation
// - Host sends exact unlock pairs
// - Third cycle carries set-up command
// - Fourth program cycle: address and data
// - Erase: second unlock pair, confirm sixth
// - Address on later fall, data on rise
// - Read only with chip and output enable low
module bbf_ctrl (
   input  wire        clk,
   input  wire        resetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   output reg  [18:0] address_lines,
   input  wire [7:0]  data_lines_in,
   output reg  [7:0]  data_lines_out,
   output reg         data_lines_oe_n,
   output reg         chip_en_n,
   output reg         out_en_n,
   output reg         write_en_n,
   output reg         reset_unprotect_n,
   output reg         high_id_voltage_level,
   input  wire        ready_busy_n
);

   localparam [2:0] S_IDLE  = 3'h0;
   localparam [2:0] S_SETUP = 3'h1;
   localparam [2:0] S_STRB  = 3'h2;
   localparam [2:0] S_RECOV = 3'h3;
   localparam [2:0] S_RST   = 3'h4;
   localparam [2:0] S_RSTW  = 3'h5;

   localparam integer WP_I     = `BBF_WP_CYC;
   localparam integer ACC_I    = `BBF_ACC_CYC;
   localparam integer REC_I    = `BBF_REC_CYC;
   localparam integer RST_I    = `BBF_RST_CYC;
   localparam integer RSTREC_I = `BBF_RSTREC_CYC;
   localparam [7:0]   WP_C     = WP_I[7:0];
   localparam [7:0]   ACC_C    = ACC_I[7:0];
   localparam [7:0]   REC_C    = REC_I[7:0];
   localparam [7:0]   RST_C    = RST_I[7:0];
   localparam [7:0]   RSTREC_C = RSTREC_I[7:0];

   reg [2:0]  state_q;
   reg [7:0]  cnt_q;
   reg [2:0]  step_q;
   reg [2:0]  op_q;
   reg        unprot_q;
   reg [18:0] addr_q;
   reg [7:0]  wdata_q;
   reg [7:0]  setup_q;
   reg [7:0]  confirm_q;
   reg [18:0] u1a_q;
   reg [7:0]  u1d_q;
   reg [18:0] u2a_q;
   reg [7:0]  u2d_q;
   reg        done_q;
   reg [7:0]  rdata_q;
   reg [7:0]  prev_q;
   reg        have_prev_q;

   wire [7:0] din_s;
   wire       rb_s;

   bbf_sync #(.W(8)) u_sync_data (
      .clk    (clk),
      .resetn (resetn),
      .din    (data_lines_in),
      .dout   (din_s)
   );

   bbf_sync #(.W(1)) u_sync_rb (
      .clk    (clk),
      .resetn (resetn),
      .din    (ready_busy_n),
      .dout   (rb_s)
   );

   // APB slave decode
   wire acc    = psel & penable;
   wire wr     = acc & pwrite;
   wire mapped = (paddr == `BBF_OFS_CTRL) || (paddr == `BBF_OFS_ADDR) ||
                 (paddr == `BBF_OFS_WDATA) || (paddr == `BBF_OFS_CODES) ||
                 (paddr == `BBF_OFS_UNLK1) || (paddr == `BBF_OFS_UNLK2) ||
                 (paddr == `BBF_OFS_STATUS);
   wire busy   = (state_q != S_IDLE);
   wire go     = wr && (paddr == `BBF_OFS_CTRL) && pwdata[`BBF_CTRL_GO]
                 && !busy;

   assign pready  = 1'b1;
   assign pslverr = acc & ~mapped;

   always @* begin
      prdata = 32'h00000000;
      case (paddr)
         `BBF_OFS_CTRL: begin
            prdata[`BBF_CTRL_OP_MSB:`BBF_CTRL_OP_LSB] = op_q;
            prdata[`BBF_CTRL_UNPROT] = unprot_q;
         end
         `BBF_OFS_ADDR:  prdata[18:0] = addr_q;
         `BBF_OFS_WDATA: prdata[7:0] = wdata_q;
         `BBF_OFS_CODES: prdata[15:0] = {confirm_q, setup_q};
         `BBF_OFS_UNLK1: prdata[26:0] = {u1a_q, u1d_q};
         `BBF_OFS_UNLK2: prdata[26:0] = {u2a_q, u2d_q};
         `BBF_OFS_STATUS: begin
            prdata[`BBF_ST_BUSY] = busy;
            prdata[`BBF_ST_DONE] = done_q;
            prdata[`BBF_ST_RDY]  = rb_s;
            prdata[`BBF_ST_RD_MSB:`BBF_ST_RD_LSB] = rdata_q;
         end
         default: prdata = 32'h00000000;
      endcase
   end

   // Current bus cycle of the instruction
   reg        st_rd;
   reg        st_last;
   reg [18:0] st_a;
   reg [7:0]  st_d;
   reg [2:0]  last_step;
   wire u1 = (step_q == 3'h0) || (step_q == 3'h3 && op_q == `BBF_OP_ERASE);
   wire u2 = (step_q == 3'h1) || (step_q == 3'h4 && op_q == `BBF_OP_ERASE);

   always @* begin
      st_rd     = 1'b0;
      st_a      = addr_q;
      st_d      = wdata_q;
      last_step = 3'h0;
      case (op_q)
         `BBF_OP_READ, `BBF_OP_POLL: st_rd = 1'b1;
         `BBF_OP_WR1:   last_step = 3'h0;
         `BBF_OP_CMD3:  last_step = 3'h2;
         `BBF_OP_PROG:  last_step = 3'h3;
         `BBF_OP_ERASE: last_step = 3'h5;
         default:       last_step = 3'h0;
      endcase
      if (op_q == `BBF_OP_CMD3 || op_q == `BBF_OP_PROG ||
          op_q == `BBF_OP_ERASE) begin
         if (u1) begin
            st_a = u1a_q;
            st_d = u1d_q;
         end else if (u2) begin
            st_a = u2a_q;
            st_d = u2d_q;
         end else if (step_q == 3'h2) begin
            st_a = u1a_q;
            st_d = setup_q;
         end else if (step_q == 3'h5) begin
            st_d = confirm_q;
         end
      end
      st_last = (step_q == last_step);
   end

   // Register writes
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         op_q      <= `BBF_OP_READ;
         unprot_q  <= 1'b0;
         addr_q    <= `BBF_RST_ADDR;
         wdata_q   <= `BBF_RST_BYTE;
         setup_q   <= `BBF_RST_BYTE;
         confirm_q <= `BBF_RST_BYTE;
         u1a_q     <= `BBF_RST_ADDR;
         u1d_q     <= `BBF_RST_BYTE;
         u2a_q     <= `BBF_RST_ADDR;
         u2d_q     <= `BBF_RST_BYTE;
      end else if (wr && !busy) begin
         case (paddr)
            `BBF_OFS_CTRL: begin
               op_q     <= pwdata[`BBF_CTRL_OP_MSB:`BBF_CTRL_OP_LSB];
               unprot_q <= pwdata[`BBF_CTRL_UNPROT];
            end
            `BBF_OFS_ADDR:  addr_q <= pwdata[18:0];
            `BBF_OFS_WDATA: wdata_q <= pwdata[7:0];
            `BBF_OFS_CODES: begin
               setup_q   <= pwdata[7:0];
               confirm_q <= pwdata[15:8];
            end
            `BBF_OFS_UNLK1: begin
               u1a_q <= pwdata[26:8];
               u1d_q <= pwdata[7:0];
            end
            `BBF_OFS_UNLK2: begin
               u2a_q <= pwdata[26:8];
               u2d_q <= pwdata[7:0];
            end
            default: ;
         endcase
      end
   end

   // Sequencer on the flash pins
   wire finish = (state_q == S_RECOV && cnt_q == REC_C && (st_rd ?
                  (op_q != `BBF_OP_POLL ||
                   (have_prev_q && prev_q[6] == rdata_q[6])) : st_last))
                 || (state_q == S_RSTW && cnt_q >= RSTREC_C && rb_s);
   wire clr_done = wr && (paddr == `BBF_OFS_STATUS) && pwdata[`BBF_ST_DONE];

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_q               <= S_IDLE;
         cnt_q                 <= 8'h00;
         step_q                <= 3'h0;
         done_q                <= 1'b0;
         rdata_q               <= 8'h00;
         prev_q                <= 8'h00;
         have_prev_q           <= 1'b0;
         address_lines         <= 19'h00000;
         data_lines_out        <= 8'h00;
         data_lines_oe_n       <= 1'b1;
         chip_en_n             <= 1'b1;
         out_en_n              <= 1'b1;
         write_en_n            <= 1'b1;
         reset_unprotect_n     <= 1'b1;
         high_id_voltage_level <= 1'b0;
      end else begin
         high_id_voltage_level <= unprot_q && reset_unprotect_n &&
                                  (state_q != S_RST);
         if (finish)
            done_q <= 1'b1;
         else if (clr_done)
            done_q <= 1'b0;
         case (state_q)
            S_IDLE: begin
               cnt_q       <= 8'h00;
               step_q      <= 3'h0;
               have_prev_q <= 1'b0;
               if (go) begin
                  if (pwdata[`BBF_CTRL_OP_MSB:`BBF_CTRL_OP_LSB] ==
                      `BBF_OP_RST)
                     state_q <= S_RST;
                  else
                     state_q <= S_SETUP;
               end
            end
            S_SETUP: begin
               address_lines   <= st_a;
               data_lines_out  <= st_d;
               data_lines_oe_n <= st_rd;
               chip_en_n       <= 1'b0;
               cnt_q           <= 8'h01;
               state_q         <= S_STRB;
            end
            S_STRB: begin
               cnt_q <= cnt_q + 8'h01;
               if (st_rd) begin
                  out_en_n <= 1'b0;
                  if (cnt_q == ACC_C + 8'h01) begin
                     rdata_q  <= din_s;
                     out_en_n <= 1'b1;
                     cnt_q    <= 8'h01;
                     state_q  <= S_RECOV;
                  end
               end else begin
                  write_en_n <= 1'b0;
                  if (cnt_q == WP_C + 8'h01) begin
                     write_en_n <= 1'b1;
                     cnt_q      <= 8'h01;
                     state_q    <= S_RECOV;
                  end
               end
            end
            S_RECOV: begin
               cnt_q <= cnt_q + 8'h01;
               if (cnt_q == REC_C) begin
                  chip_en_n       <= 1'b1;
                  data_lines_oe_n <= 1'b1;
                  if (finish) begin
                     state_q <= S_IDLE;
                  end else begin
                     if (op_q == `BBF_OP_POLL) begin
                        prev_q      <= rdata_q;
                        have_prev_q <= 1'b1;
                     end else begin
                        step_q <= step_q + 3'h1;
                     end
                     state_q <= S_SETUP;
                  end
               end
            end
            S_RST: begin
               reset_unprotect_n <= 1'b0;
               cnt_q             <= cnt_q + 8'h01;
               if (cnt_q == RST_C) begin
                  reset_unprotect_n <= 1'b1;
                  cnt_q             <= 8'h00;
                  state_q           <= S_RSTW;
               end
            end
            S_RSTW: begin
               if (cnt_q < RSTREC_C)
                  cnt_q <= cnt_q + 8'h01;
               if (finish)
                  state_q <= S_IDLE;
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

endmodule

`default_nettype wire

// [common/bbf_map.vh]
`ifndef BBF_MAP_VH
`define BBF_MAP_VH

// Register offsets
`define BBF_OFS_CTRL   12'h000
`define BBF_OFS_ADDR   12'h004
`define BBF_OFS_WDATA  12'h008
`define BBF_OFS_CODES  12'h00c
`define BBF_OFS_UNLK1  12'h010
`define BBF_OFS_UNLK2  12'h014
`define BBF_OFS_STATUS 12'h018

// Control fields
`define BBF_CTRL_OP_LSB  0
`define BBF_CTRL_OP_MSB  2
`define BBF_CTRL_GO      8
`define BBF_CTRL_UNPROT  9

// Status fields
`define BBF_ST_BUSY      0
`define BBF_ST_DONE      1
`define BBF_ST_RDY       2
`define BBF_ST_RD_LSB    8
`define BBF_ST_RD_MSB    15

// Reset values
`define BBF_RST_ADDR     19'h00000
`define BBF_RST_BYTE     8'h00

// Operations
`define BBF_OP_READ      3'h0
`define BBF_OP_WR1       3'h1
`define BBF_OP_CMD3      3'h2
`define BBF_OP_PROG      3'h3
`define BBF_OP_ERASE     3'h4
`define BBF_OP_POLL      3'h5
`define BBF_OP_RST       3'h6

// Timing in ns and derived cycle counts at 25 MHz
`define BBF_CLK_MHZ      25
`define BBF_WP_NS        50
`define BBF_ACC_NS       120
`define BBF_REC_NS       50
`define BBF_RST_NS       500
`define BBF_RSTREC_NS    1000
`define BBF_CYC(ns)      (((ns) * `BBF_CLK_MHZ + 999) / 1000)
`define BBF_WP_CYC       `BBF_CYC(`BBF_WP_NS)
`define BBF_ACC_CYC      (`BBF_CYC(`BBF_ACC_NS) + 2)
`define BBF_REC_CYC      `BBF_CYC(`BBF_REC_NS)
`define BBF_RST_CYC      `BBF_CYC(`BBF_RST_NS)
`define BBF_RSTREC_CYC   `BBF_CYC(`BBF_RSTREC_NS)

`endif

// [rtl/bbf_sync.v]
`timescale 1ns/1ps
`default_nettype none

module bbf_sync #(
   parameter W = 1
) (
   input  wire         clk,
   input  wire         resetn,
   input  wire [W-1:0] din,
   output reg  [W-1:0] dout
);

   reg [W-1:0] meta_q;

   // Two-stage synchroniser
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         meta_q <= {W{1'b0}};
         dout   <= {W{1'b0}};
      end else begin
         meta_q <= din;
         dout   <= meta_q;
      end
   end

endmodule

`default_nettype wire

// [bench/bbf_ctrl_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module bbf_ctrl_monitor (
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic [18:0] address_lines,
   input wire logic [7:0]  data_lines_out,
   input wire logic        data_lines_oe_n,
   input wire logic        chip_en_n,
   input wire logic        out_en_n,
   input wire logic        write_en_n,
   input wire logic        reset_unprotect_n,
   input wire logic        high_id_voltage_level
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   a_we_in_ce: assert property (
      !write_en_n |-> !chip_en_n && out_en_n) else $error("stray strobe");
   a_we_drives: assert property (
      !write_en_n |-> !data_lines_oe_n) else $error("write undriven");
   a_read_quiet: assert property (
      !out_en_n |-> data_lines_oe_n && !chip_en_n) else $error("contention");
   a_we_stable: assert property (
      !write_en_n && $past(!write_en_n) |-> $stable(address_lines)
      && $stable(data_lines_out)) else $error("moved in write");
   a_we_width: assert property (
      $fell(write_en_n) |=> !write_en_n ##[1:3] write_en_n)
      else $error("strobe width");
   a_read_hold: assert property (
      $fell(out_en_n) |-> (!out_en_n && $stable(address_lines)) [*4])
      else $error("read too short");
   a_rst_pulse: assert property (
      $fell(reset_unprotect_n) |-> !reset_unprotect_n [*8]
      ##[1:12] reset_unprotect_n) else $error("reset pulse length");
   a_id_in_rst: assert property (
      !reset_unprotect_n |-> !high_id_voltage_level) else $error("id level");
endmodule
bind bbf_ctrl bbf_ctrl_monitor MON (.clk(clk), .resetn(resetn),
   .address_lines(address_lines), .data_lines_out(data_lines_out),
   .data_lines_oe_n(data_lines_oe_n), .chip_en_n(chip_en_n),
   .out_en_n(out_en_n), .write_en_n(write_en_n),
   .reset_unprotect_n(reset_unprotect_n),
   .high_id_voltage_level(high_id_voltage_level));
`default_nettype wire

// [bench/bbf_flash_model.sv]
`timescale 1ns/1ps
`default_nettype none
module bbf_flash_model (
   input  wire logic [18:0] a,
   input  wire logic [7:0]  cd,
   input  wire logic        cd_oe_n,
   input  wire logic        ce_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic        rp_n,
   output var  logic [7:0]  dq,
   output var  logic        rb_n
);
   // Codes and ident byte are arbitrary stand-ins
   localparam logic [18:0] U1A = 19'h00555;
   localparam logic [18:0] U2A = 19'h002aa;
   localparam logic [7:0]  U1D = 8'haa;
   localparam logic [7:0]  U2D = 8'h55;
   localparam logic [7:0]  PRG = 8'ha0;
   localparam logic [7:0]  ERS = 8'h80;
   localparam logic [7:0]  CNF = 8'h30;
   localparam logic [7:0]  ASL = 8'h90;
   localparam logic [7:0]  MFR = 8'h5a;
   logic [7:0]  mem [0:19'h7ffff];
   logic [7:0]  cmd = 8'h00;
   logic [7:0]  pd = 8'h00;
   logic [18:0] la = 19'h0;
   logic [2:0]  cyc = 3'h0;
   logic        asel = 1'b0;
   logic        tog = 1'b0;
   logic        ok;
   initial begin
      rb_n = 1'b1;
      foreach (mem[i]) mem[i] = 8'hff;
   end
   task automatic run(input logic [7:0] d);
      pd = d;
      rb_n = 1'b0;
      #2000 rb_n = 1'b1;
   endtask
   always @(negedge we_n) if (!ce_n) la = a;
   always @(posedge we_n) if (!ce_n && rp_n && rb_n) begin
      if (cyc == 0 || (cyc == 3 && cmd != PRG)) ok = la == U1A && cd == U1D;
      else if (cyc == 1 || cyc == 4) ok = la == U2A && cd == U2D;
      else ok = 1'b1;
      cyc = ok ? cyc + 3'h1 : 3'h0;
      if (!ok) asel = 1'b0;
      if (cyc == 3) begin
         cmd = cd;
         asel = cd == ASL;
         if (cd != PRG && cd != ERS) cyc = 3'h0;
      end else if (cyc == 4 && cmd == PRG) begin
         mem[la] = cd;
         cyc = 3'h0;
         run(cd);
      end else if (cyc == 6) begin
         cyc = 3'h0;
         if (cd == CNF) begin
            foreach (mem[i]) mem[i] = 8'hff;
            run(8'hff);
         end
      end
   end
   always @(negedge rp_n) begin
      cyc = 3'h0;
      asel = 1'b0;
   end
   always @(negedge oe_n) if (!ce_n && !rb_n) tog = ~tog;
   always_comb begin
      if (!cd_oe_n) dq = cd;
      else if (ce_n || oe_n || !rp_n) dq = ~cd;
      else if (!rb_n) dq = {~pd[7], tog, 3'h0, tog, 2'h0};
      else if (asel) dq = MFR;
      else dq = mem[a];
   end
endmodule
`default_nettype wire

// [bench/bbf_ctrl_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module bbf_ctrl_tb;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, r;
   logic        pready, err, oe, ce, re, we, rp, hid, rb;
   logic [18:0] fa;
   logic [7:0]  dq_o, dq_i;
   int          failures = 0;
   int          total_checks = 0;
   int          n;
   always #20 clk = ~clk;
   bbf_ctrl DUT (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(err), .address_lines(fa),
      .data_lines_in(dq_i), .data_lines_out(dq_o), .data_lines_oe_n(oe),
      .chip_en_n(ce), .out_en_n(re), .write_en_n(we),
      .reset_unprotect_n(rp), .high_id_voltage_level(hid), .ready_busy_n(rb));
   bbf_flash_model FM (.a(fa), .cd(dq_o), .cd_oe_n(oe), .ce_n(ce),
      .oe_n(re), .we_n(we), .rp_n(rp), .dq(dq_i), .rb_n(rb));
   task automatic test_done;
      if (failures == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(r, e);
   endtask
   task automatic fin;
      n = 0;
      do begin
         xfer(1'b0, 12'h018, 32'h0);
         n++;
      end while (r[1] !== 1'b1 && n < 3000);
      chk({31'h0, r[1]}, 32'h1);
      xfer(1'b1, 12'h018, 32'h2);
   endtask
   task automatic op(input logic [31:0] c);
      xfer(1'b1, 12'h000, c);
      fin();
   endtask
   initial begin
      #400000;
      failures++;
      test_done();
   end
   initial begin
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      rc(12'h000, 32'h0);
      rc(12'h004, 32'h0);
      rc(12'h018, 32'h4);
      rc(12'h01c, 32'h0);
      chk({31'h0, err}, 32'h1);
      xfer(1'b1, 12'h010, {5'h0, FM.U1A, FM.U1D});
      xfer(1'b1, 12'h014, {5'h0, FM.U2A, FM.U2D});
      xfer(1'b1, 12'h00c, {16'h0, FM.CNF, FM.PRG});
      xfer(1'b1, 12'h004, 32'h7c010);
      xfer(1'b1, 12'h008, 32'h3c);
      op(32'h103);
      rc(12'h018, 32'h0);
      op(32'h105);
      rc(12'h018, 32'h3c04);
      xfer(1'b1, 12'h00c, {24'h0, FM.ASL});
      xfer(1'b1, 12'h004, 32'h0);
      op(32'h102);
      op(32'h100);
      rc(12'h018, {16'h0, FM.MFR, 8'h04});
      xfer(1'b1, 12'h008, 32'h0f);
      op(32'h101);
      op(32'h100);
      rc(12'h018, 32'hff04);
      xfer(1'b1, 12'h00c, {16'h0, FM.CNF, FM.ERS});
      xfer(1'b1, 12'h004, 32'h7c010);
      xfer(1'b1, 12'h000, 32'h104);
      xfer(1'b1, 12'h004, 32'h1);
      rc(12'h004, 32'h7c010);
      fin();
      op(32'h105);
      op(32'h100);
      rc(12'h018, 32'hff04);
      op(32'h306);
      rc(12'h000, 32'h206);
      chk({31'h0, hid}, 32'h1);
      test_done();
   end
endmodule
`default_nettype wire
